// *** pkg/pdl_pkg.sv ***
// Package for the two-port data latch block: offsets, fields, resets
package pdl_pkg;
  // Register byte offsets
  localparam logic [7:0] PORT0_LATCH_OFF = 8'h80;
  localparam logic [7:0] PORT1_LATCH_OFF = 8'h90;
  localparam logic [7:0] PORT0_MODE_OFF  = 8'hA0;
  localparam logic [7:0] PORT1_MODE_OFF  = 8'hA4;
  localparam logic [7:0] XBAR_A_OFF      = 8'hB0;
  localparam logic [7:0] XBAR_B_OFF      = 8'hB4;
  localparam logic [7:0] XBAR_C_OFF      = 8'hB8;
  localparam logic [7:0] XBAR_D_OFF      = 8'hBC;
  localparam logic [7:0] BITOP_OFF       = 8'hC0;
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] XBAR_RST  = 8'h00;
  // Bit operation register fields
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_PORT    = 3;
  localparam int BITOP_VAL     = 4;
  // Memory strobe pins on port 0
  localparam int EMIF_WR_PIN  = 7;
  localparam int EMIF_RD_PIN  = 6;
  localparam int EMIF_ALE_PIN = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** pkg/pdl_pin_if.sv ***
// Interface carrying one port's latch, mode and routing toward its pad driver
`timescale 1ns/1ps
interface pdl_pin_if;
  logic [7:0] latch;
  logic [7:0] push_pull;
  logic [7:0] periph_sel;
  logic [7:0] periph_val;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  modport ctrl (output latch, push_pull, periph_sel, periph_val,
                input pad_out, pad_oe_n);
  modport drv  (input latch, push_pull, periph_sel, periph_val,
                output pad_out, pad_oe_n);
endinterface // pdl_pin_if

// *** design/pdl_pad_drv.sv ***
// Pad driver for one byte-wide port: latch or peripheral, open or push-pull
`timescale 1ns/1ps
module pdl_pad_drv (
  // Port signals
  pdl_pin_if.drv pins
);
  wire [7:0] src;
  // Routed source: peripheral wins where the crossbar hands the pin over
  assign src = (pins.periph_sel & pins.periph_val) |
               (~pins.periph_sel & pins.latch);
  // Pad value is the routed source; the enable alone decides whether it shows
  assign pins.pad_out = src;
  // Low drives; high drives only in push-pull mode, else left open
  assign pins.pad_oe_n = ~(~src | pins.push_pull);
endmodule // pdl_pad_drv

// *** design/pdl_top.sv ***
// Two-port data latch block with AXI4-Lite register access
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module pdl_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory interface strobes for port 0 pins 7..5
  input  wire logic        emif_active,
  input  wire logic        emif_wr_n,
  input  wire logic        emif_rd_n,
  input  wire logic        emif_ale,
  // Peripheral values routed by the crossbar
  input  wire logic [7:0]  port0_periph_val,
  input  wire logic [7:0]  port1_periph_val,
  // Pads: input level, output value, output enable (low drives)
  input  wire logic [7:0]  port0_pad_in,
  output logic [7:0]       port0_pad_out,
  output logic [7:0]       port0_pad_oe_n,
  input  wire logic [7:0]  port1_pad_in,
  output logic [7:0]       port1_pad_out,
  output logic [7:0]       port1_pad_oe_n
);
  logic [7:0] port0_latch_r, port1_latch_r, port0_mode_r, port1_mode_r;
  logic [7:0] xa_r, xb_r, xc_r, xd_r;
  logic [7:0] port0_sync1_r, port0_sync2_r, port1_sync1_r, port1_sync2_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r;
  logic [7:0] port0_sel, port1_sel, port0_route_val;
  wire do_write;
  wire wr_lane0;
  wire [7:0] wb;
  wire wr_ok;
  wire [31:0] rd_word;
  wire rd_ok;

  pdl_pin_if port0_if ();
  pdl_pin_if port1_if ();

  // Byte-wide merge of bit operation: one target bit set or cleared
  function automatic logic [7:0] bit_op(input logic [7:0] cur,
                                        input logic [2:0] idx,
                                        input logic val);
    logic [7:0] r;
    r = cur;
    r[idx] = val;
    return r;
  endfunction

  // Crossbar: a pin belongs to a peripheral when any config bit claims it
  assign port0_sel = xa_r | xb_r;
  assign port1_sel = xc_r | xd_r;
  // Strobes replace latch on port 0 top pins when the memory bus runs
  assign port0_route_val = emif_active ?
    {emif_wr_n, emif_rd_n, emif_ale, port0_periph_val[4:0]} :
    port0_periph_val;
  assign port0_if.latch      = port0_latch_r;
  assign port0_if.push_pull  = port0_mode_r;
  assign port0_if.periph_sel = emif_active ? (port0_sel | 8'hE0) :
                               port0_sel;
  assign port0_if.periph_val = port0_route_val;
  assign port1_if.latch      = port1_latch_r;
  assign port1_if.push_pull  = port1_mode_r;
  assign port1_if.periph_sel = port1_sel;
  assign port1_if.periph_val = port1_periph_val;

  pdl_pad_drv u_pdl_pad_drv0 (.pins(port0_if.drv));
  pdl_pad_drv u_pdl_pad_drv1 (.pins(port1_if.drv));

  // Write channel accepted when both halves are held
  assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_lane0 = w_strb_r[0];
  assign wb = w_data_r[7:0];
  assign wr_ok = (aw_addr_r == pdl_pkg::PORT0_LATCH_OFF) |
                 (aw_addr_r == pdl_pkg::PORT1_LATCH_OFF) |
                 (aw_addr_r == pdl_pkg::PORT0_MODE_OFF) |
                 (aw_addr_r == pdl_pkg::PORT1_MODE_OFF) |
                 (aw_addr_r == pdl_pkg::XBAR_A_OFF) |
                 (aw_addr_r == pdl_pkg::XBAR_B_OFF) |
                 (aw_addr_r == pdl_pkg::XBAR_C_OFF) |
                 (aw_addr_r == pdl_pkg::XBAR_D_OFF) |
                 (aw_addr_r == pdl_pkg::BITOP_OFF);

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Ready is registered; taken once per write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready) &
                       ~s_axi_bvalid;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pdl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? pdl_pkg::RESP_OKAY : pdl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Latches: byte write on lane 0, or single bit set/clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_latch_r <= pdl_pkg::LATCH_RST;
      port1_latch_r <= pdl_pkg::LATCH_RST;
    end else if (do_write && wr_lane0) begin
      if (aw_addr_r == pdl_pkg::PORT0_LATCH_OFF)
        port0_latch_r <= wb;
      if (aw_addr_r == pdl_pkg::PORT1_LATCH_OFF)
        port1_latch_r <= wb;
      if (aw_addr_r == pdl_pkg::BITOP_OFF && !wb[pdl_pkg::BITOP_PORT])
        port0_latch_r <= bit_op(port0_latch_r, wb[2:0],
                                wb[pdl_pkg::BITOP_VAL]);
      if (aw_addr_r == pdl_pkg::BITOP_OFF && wb[pdl_pkg::BITOP_PORT])
        port1_latch_r <= bit_op(port1_latch_r, wb[2:0],
                                wb[pdl_pkg::BITOP_VAL]);
    end
  end

  // Mode and crossbar configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_mode_r <= pdl_pkg::MODE_RST;
      port1_mode_r <= pdl_pkg::MODE_RST;
      xa_r <= pdl_pkg::XBAR_RST;
      xb_r <= pdl_pkg::XBAR_RST;
      xc_r <= pdl_pkg::XBAR_RST;
      xd_r <= pdl_pkg::XBAR_RST;
    end else if (do_write && wr_lane0) begin
      if (aw_addr_r == pdl_pkg::PORT0_MODE_OFF) port0_mode_r <= wb;
      if (aw_addr_r == pdl_pkg::PORT1_MODE_OFF) port1_mode_r <= wb;
      if (aw_addr_r == pdl_pkg::XBAR_A_OFF) xa_r <= wb;
      if (aw_addr_r == pdl_pkg::XBAR_B_OFF) xb_r <= wb;
      if (aw_addr_r == pdl_pkg::XBAR_C_OFF) xc_r <= wb;
      if (aw_addr_r == pdl_pkg::XBAR_D_OFF) xd_r <= wb;
    end
  end

  // Pin synchronisers; pads are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_sync1_r <= 8'hFF;
      port0_sync2_r <= 8'hFF;
      port1_sync1_r <= 8'hFF;
      port1_sync2_r <= 8'hFF;
    end else begin
      port0_sync1_r <= port0_pad_in;
      port0_sync2_r <= port0_sync1_r;
      port1_sync1_r <= port1_pad_in;
      port1_sync2_r <= port1_sync1_r;
    end
  end

  // Read decode: data offsets show pin levels, not latch contents
  assign rd_word =
    (s_axi_araddr[7:2] == pdl_pkg::PORT0_LATCH_OFF[7:2]) ?
      {24'h0, port0_sync2_r} :
    (s_axi_araddr[7:2] == pdl_pkg::PORT1_LATCH_OFF[7:2]) ?
      {24'h0, port1_sync2_r} :
    (s_axi_araddr[7:2] == pdl_pkg::PORT0_MODE_OFF[7:2]) ?
      {24'h0, port0_mode_r} :
    (s_axi_araddr[7:2] == pdl_pkg::PORT1_MODE_OFF[7:2]) ?
      {24'h0, port1_mode_r} :
    (s_axi_araddr[7:2] == pdl_pkg::XBAR_A_OFF[7:2]) ? {24'h0, xa_r} :
    (s_axi_araddr[7:2] == pdl_pkg::XBAR_B_OFF[7:2]) ? {24'h0, xb_r} :
    (s_axi_araddr[7:2] == pdl_pkg::XBAR_C_OFF[7:2]) ? {24'h0, xc_r} :
    (s_axi_araddr[7:2] == pdl_pkg::XBAR_D_OFF[7:2]) ? {24'h0, xd_r} :
    32'h0000_0000;
  assign rd_ok = (s_axi_araddr[7:2] == pdl_pkg::PORT0_LATCH_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::PORT1_LATCH_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::PORT0_MODE_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::PORT1_MODE_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::XBAR_A_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::XBAR_B_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::XBAR_C_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::XBAR_D_OFF[7:2]) |
                 (s_axi_araddr[7:2] == pdl_pkg::BITOP_OFF[7:2]);

  // Read channel: arready pulses, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pdl_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? pdl_pkg::RESP_OKAY : pdl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pad outputs registered so every pin control leaves a flop, no glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_pad_out  <= 8'h00;
      port0_pad_oe_n <= 8'hFF;
      port1_pad_out  <= 8'h00;
      port1_pad_oe_n <= 8'hFF;
    end else begin
      port0_pad_out  <= port0_if.pad_out;
      port0_pad_oe_n <= port0_if.pad_oe_n;
      port1_pad_out  <= port1_if.pad_out;
      port1_pad_oe_n <= port1_if.pad_oe_n;
    end
  end

  // Assertions
  property p_low_drives;
    @(posedge aclk) disable iff (!aresetn)
    (port1_sel[0] == 1'b0 && port1_latch_r[0] == 1'b0) |=>
      (port1_pad_oe_n[0] == 1'b0 && port1_pad_out[0] == 1'b0);
  endproperty
  a_low_drives: assert property (p_low_drives)
    else $error("latch zero did not drive low");
  property p_open_high;
    @(posedge aclk) disable iff (!aresetn)
    (port1_sel[1] == 1'b0 && port1_latch_r[1] && !port1_mode_r[1]) |=>
      port1_pad_oe_n[1];
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("open drain high was driven");
  property p_pp_high;
    @(posedge aclk) disable iff (!aresetn)
    (port0_if.periph_sel[2] == 1'b0 && port0_latch_r[2] &&
     port0_mode_r[2]) |=>
      (!port0_pad_oe_n[2] && port0_pad_out[2]);
  endproperty
  a_pp_high: assert property (p_pp_high)
    else $error("push pull high not driven");
  property p_pin_read;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready &&
     s_axi_araddr[7:2] == pdl_pkg::PORT0_LATCH_OFF[7:2]) |=>
      s_axi_rdata[7:0] == $past(port0_sync2_r);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("port read not pin level");
  property p_strobe;
    @(posedge aclk) disable iff (!aresetn)
    emif_active |=> port0_pad_out[7] == $past(emif_wr_n);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("write strobe not on pin");
  property p_byte_wr;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 && aw_addr_r == pdl_pkg::PORT1_LATCH_OFF) |=>
      port1_latch_r == $past(wb);
  endproperty
  a_byte_wr: assert property (p_byte_wr)
    else $error("port 1 byte write lost");
  property p_bit_wr;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_lane0 && aw_addr_r == pdl_pkg::BITOP_OFF &&
     !wb[pdl_pkg::BITOP_PORT]) |=>
      port0_latch_r[$past(wb[2:0])] == $past(wb[pdl_pkg::BITOP_VAL]);
  endproperty
  a_bit_wr: assert property (p_bit_wr)
    else $error("bit operation failed");
  property p_xbar_owns;
    @(posedge aclk) disable iff (!aresetn)
    (!emif_active && xa_r[3]) |=>
      port0_pad_out[3] == $past(port0_periph_val[3]);
  endproperty
  a_xbar_owns: assert property (p_xbar_owns)
    else $error("routed pin followed latch");
  property p_reset_ones;
    @(posedge aclk) !aresetn |=> (port0_latch_r == pdl_pkg::LATCH_RST &&
                                 port1_latch_r == pdl_pkg::LATCH_RST);
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("latch reset value wrong");
  property p_bresp_once;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bresp_once: assert property (p_bresp_once)
    else $error("write response dropped");

  c_write: cover property (@(posedge aclk) do_write && wr_ok);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_strobe: cover property (@(posedge aclk) emif_active && !emif_rd_n);
  c_bitop: cover property (@(posedge aclk)
    do_write && aw_addr_r == pdl_pkg::BITOP_OFF);
endmodule // pdl_top

// *** tb/pdl_board.sv ***
// Board model: pads with pull-ups and an optional external low driver
`timescale 1ns/1ps
module pdl_board (
  // Pad drive from the block
  input  wire logic [7:0] port0_out,
  input  wire logic [7:0] port0_oe_n,
  input  wire logic [7:0] port1_out,
  input  wire logic [7:0] port1_oe_n,
  // Pins pulled low by outside circuitry
  input  wire logic [7:0] port0_ext,
  input  wire logic [7:0] port1_ext,
  // Resolved pin levels
  output logic [7:0]      port0_pin,
  output logic [7:0]      port1_pin
);
  // A released pin rests at the pull-up unless something outside holds it
  // low; the block's own driver wins where both would act
  assign port0_pin = (~port0_oe_n & port0_out) |
                     (port0_oe_n & ~port0_ext);
  assign port1_pin = (~port1_oe_n & port1_out) |
                     (port1_oe_n & ~port1_ext);
endmodule // pdl_board

// *** tb/test_port0_port1_data_latches.sv ***
// Self-checking bench for the two-port data latch block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); \
  end \
end
module test_port0_port1_data_latches;
  // Clock, reset and bus
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, eb;
  logic [31:0] rdata;
  // Strobes, peripherals, pads
  logic        emif_on = 1'b0, wr_n = 1'b1, rd_n = 1'b1, ale = 1'b0;
  logic [7:0]  per0 = 8'h00, per1 = 8'h00, ext0 = 8'h00, ext1 = 8'h00;
  logic [7:0]  pin0, pin1, out0, oe0, out1, oe1;
  // Shadow state for expectations
  logic [7:0]  lat0 = 8'hFF, lat1 = 8'hFF, md0 = 8'h00, md1 = 8'h00;
  logic [7:0]  xa = 8'h00, xb = 8'h00, xc = 8'h00, xd = 8'h00;
  logic [1:0]  bq[$];
  logic [33:0] rq[$], er;
  int          error_cnt = 0, check_count = 0;

  always #20 aclk = ~aclk;

  pdl_top u_pdl_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .emif_active(emif_on), .emif_wr_n(wr_n),
    .emif_rd_n(rd_n), .emif_ale(ale), .port0_periph_val(per0),
    .port1_periph_val(per1), .port0_pad_in(pin0), .port0_pad_out(out0),
    .port0_pad_oe_n(oe0), .port1_pad_in(pin1), .port1_pad_out(out1),
    .port1_pad_oe_n(oe1));

  pdl_board u_pdl_board (.port0_out(out0), .port0_oe_n(oe0),
    .port1_out(out1), .port1_oe_n(oe1), .port0_ext(ext0),
    .port1_ext(ext1), .port0_pin(pin0), .port1_pin(pin1));

  // Verdict and end of run
  task automatic conclude();
    $display("Counts: %0d mismatches, %0d comparisons", error_cnt,
             check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait step; a hung handshake ends the run
  task automatic tick(inout int n);
    n++;
    if (n > 100) begin
      error_cnt++;
      conclude();
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] e);
    int n;
    n = 0;
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
      tick(n);
    end while (awvalid || wvalid || bready);
  endtask

  // Read: expected response and data noted before the request
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
      tick(n);
    end while (arvalid || rready);
  endtask

  // Full-word register write that keeps the shadow state in step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axw(a, d, 4'hF, pdl_pkg::RESP_OKAY);
    case (a)
      pdl_pkg::PORT0_LATCH_OFF: lat0 = d;
      pdl_pkg::PORT1_LATCH_OFF: lat1 = d;
      pdl_pkg::PORT0_MODE_OFF:  md0 = d;
      pdl_pkg::PORT1_MODE_OFF:  md1 = d;
      pdl_pkg::XBAR_A_OFF:      xa = d;
      pdl_pkg::XBAR_B_OFF:      xb = d;
      pdl_pkg::XBAR_C_OFF:      xc = d;
      default:                  xd = d;
    endcase
  endtask

  // Pads and pin reads against the routed value and output mode
  task automatic chk();
    logic [7:0] v0, v1, o0, o1;
    // Pads settle a cycle after a write, pin sync takes two more
    repeat (4) @(posedge aclk);
    v0 = ((xa | xb) & per0) | (~(xa | xb) & lat0);
    if (emif_on) v0[7:5] = {wr_n, rd_n, ale};
    v1 = ((xc | xd) & per1) | (~(xc | xd) & lat1);
    o0 = v0 & ~md0;
    o1 = v1 & ~md1;
    `CHK("port0 oe_n", o0, oe0)
    `CHK("port0 drive", v0 & ~o0, out0 & ~oe0)
    `CHK("port1 oe_n", o1, oe1)
    `CHK("port1 drive", v1 & ~o1, out1 & ~oe1)
    rd(pdl_pkg::PORT0_LATCH_OFF, {26'h0, v0 & ~(o0 & ext0)});
    rd(pdl_pkg::PORT1_LATCH_OFF, {26'h0, v1 & ~(o1 & ext1)});
  endtask

  // Response watcher: oldest note against each answer
  always @(posedge aclk) begin
    if (bvalid && bready && bq.size() > 0) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready && rq.size() > 0) begin
      er = rq.pop_front();
      `CHK("rresp rdata", er, {rresp, rdata})
    end
  end

  // Main sequence
  initial begin
    void'($urandom(99108));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("port0 oe_n rst", 8'hFF, oe0)
    `CHK("port1 oe_n rst", 8'hFF, oe1)
    chk();
    // Random latches, modes, routing, strobes and outside loads
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      per0 <= 8'($urandom);
      per1 <= 8'($urandom);
      ext0 <= 8'($urandom);
      ext1 <= 8'($urandom);
      emif_on <= i[0];
      {wr_n, rd_n, ale} <= 3'($urandom);
      wr(pdl_pkg::PORT0_LATCH_OFF, 8'($urandom));
      wr(pdl_pkg::PORT1_LATCH_OFF, 8'($urandom));
      wr(pdl_pkg::PORT0_MODE_OFF, 8'($urandom));
      wr(pdl_pkg::PORT1_MODE_OFF, 8'($urandom));
      wr(pdl_pkg::XBAR_A_OFF, 8'($urandom & $urandom & {8{i[1]}}));
      wr(pdl_pkg::XBAR_B_OFF, 8'($urandom & $urandom));
      wr(pdl_pkg::XBAR_C_OFF, 8'($urandom & $urandom & {8{i[2]}}));
      wr(pdl_pkg::XBAR_D_OFF, 8'($urandom & $urandom));
      chk();
    end
    // Single-bit set and clear on both ports
    for (int i = 0; i < 32; i++) begin
      logic [7:0] d;
      d = 8'h00;
      d[2:0] = i[2:0];
      d[pdl_pkg::BITOP_PORT] = i[3];
      d[pdl_pkg::BITOP_VAL] = i[4] ^ i[0];
      axw(pdl_pkg::BITOP_OFF, d, 4'hF, pdl_pkg::RESP_OKAY);
      if (i[3]) lat1[i[2:0]] = d[pdl_pkg::BITOP_VAL];
      else lat0[i[2:0]] = d[pdl_pkg::BITOP_VAL];
      if (i[1:0] == 2'h3) chk();
    end
    // Unmapped place, disabled byte lane, write-only place
    axw(8'hF0, 8'h00, 4'hF, pdl_pkg::RESP_SLVERR);
    rd(8'hF0, {pdl_pkg::RESP_SLVERR, 32'h0});
    axw(pdl_pkg::PORT0_LATCH_OFF, ~lat0, 4'h0, pdl_pkg::RESP_OKAY);
    rd(pdl_pkg::BITOP_OFF, {pdl_pkg::RESP_OKAY, 32'h0});
    chk();
    conclude();
  end
endmodule // test_port0_port1_data_latches
